// ### hw/lcd_pkg.sv
// Shared constants, types and register map of the LCD segment/common driver
package lcd_pkg;

  // Geometry
  localparam int NUM_SEG       = 40;
  localparam int NUM_COM       = 4;
  localparam int NUM_PORT      = 16;
  localparam int PORT_SEG_BASE = 24;
  localparam int PORT_HALF     = 8;
  localparam int DMEM_BITS     = 4;
  localparam int ADDR_W        = 16;
  localparam int DATA_W        = 32;

  // Register byte addresses
  localparam logic [15:0] MODE_OFS     = 16'hffb0;
  localparam logic [15:0] PIN_CTRL_OFS = 16'hffb4;
  localparam logic [15:0] WTM_OFS      = 16'hffb8;
  localparam logic [15:0] PORT_OFS     = 16'hffbc;
  localparam logic [15:0] PULLUP_OFS   = 16'hffc0;
  localparam logic [15:0] STATUS_OFS   = 16'hffc4;
  localparam logic [15:0] DMEM_BASE    = 16'hfe00;
  localparam logic [15:0] DMEM_LAST    = 16'hfe9c;

  // Reset values
  localparam logic [7:0]  MODE_RESET      = 8'h00;
  localparam logic [7:0]  PIN_CTRL_RESET  = 8'h00;
  localparam logic [1:0]  WTM_RESET       = 2'h0;
  localparam logic [1:0]  PULLUP_RESET    = 2'h0;
  localparam logic [15:0] PORT_DATA_RESET = 16'h0000;
  localparam logic [15:0] PORT_DIR_RESET  = 16'hffff;

  // Field positions
  localparam int MODE_ON_BIT    = 7;
  localparam int MODE_FRAME_LSB = 4;
  localparam int MODE_LV_BIT    = 3;
  localparam int MODE_DUTY_LSB  = 0;
  localparam int WTM_SRC_BIT    = 0;
  localparam int WTM_PRESC_BIT  = 1;
  localparam int PORT_DIR_LSB   = 16;
  localparam int ST_POL_BIT     = 2;
  localparam int ST_DUTY_LSB    = 3;
  localparam int ST_FRAME_LSB   = 6;

  // Clock division
  localparam int          MAIN_PRESCALE_LOG2 = 7;
  localparam int          FRAME_LOG2_SLOWEST = 9;
  localparam logic [2:0]  FRAME_CODE_MAX     = 3'h3;

  // Drive levels as steps of the bias ladder
  localparam logic [1:0] LVL_ZERO = 2'h0;
  localparam logic [1:0] LVL_ONE  = 2'h1;
  localparam logic [1:0] LVL_TWO  = 2'h2;
  localparam logic [1:0] LVL_TOP  = 2'h3;

  typedef enum logic [2:0] {DUTY_4_THIRD, DUTY_3_THIRD, DUTY_2_HALF, DUTY_3_HALF, DUTY_STATIC} duty_type;

  typedef enum logic [2:0] {REG_NONE, REG_MODE, REG_PIN, REG_WTM, REG_PORT, REG_PULL, REG_STAT,
                            REG_DMEM} reg_id_type;

  typedef struct packed {
    duty_type   duty;
    logic [2:0] frame_sel;
  } lcd_cfg_type;

endpackage : lcd_pkg

// ### hw/lcd_clock_gen.sv
// Watch timer clock source and LCD slot clock divider
`timescale 1ns/1ps
`default_nettype none

module lcd_clock_gen (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       sub_osc_clk,
  input  wire logic       use_sub_clk,
  input  wire logic       prescaler_en,
  input  wire logic [2:0] frame_sel,
  output logic            lcd_tick
);

  logic [2:0]                                sync_reg, sync_next;
  logic                                      sub_lvl_reg, sub_lvl_next;
  logic [lcd_pkg::MAIN_PRESCALE_LOG2-1:0]    presc_reg, presc_next;
  logic [lcd_pkg::FRAME_LOG2_SLOWEST-1:0]    div_reg, div_next;
  logic                                      tick_reg, tick_next;
  logic                                      fw_tick;
  logic [lcd_pkg::FRAME_LOG2_SLOWEST-1:0]    div_mask;

  // Watch clock pick, divide by 2^(9-sel) for sel 0-3 (by 512 for higher codes), stop when prescaler is off
  always_comb begin
    sync_next    = {sync_reg[1:0], sub_osc_clk};
    sub_lvl_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : sub_lvl_reg;
    presc_next   = presc_reg;
    div_next     = div_reg;
    tick_next    = 1'b0;
    div_mask     = '1;
    if (frame_sel <= lcd_pkg::FRAME_CODE_MAX)
      div_mask = div_mask >> frame_sel;
    // Main clock over 128 or sub clock
    if (use_sub_clk)
      fw_tick = sub_lvl_next & ~sub_lvl_reg;
    else
      fw_tick = (presc_reg == '1);
    if (!prescaler_en) begin
      presc_next = '0;
      div_next   = '0;
    end else begin
      presc_next = presc_reg + 1'b1;
      if (fw_tick) begin
        div_next  = div_reg + 1'b1;
        tick_next = ((div_reg & div_mask) == div_mask);
      end
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg    <= '0;
      sub_lvl_reg <= 1'b0;
      presc_reg   <= '0;
      div_reg     <= '0;
      tick_reg    <= 1'b0;
    end else begin
      sync_reg    <= sync_next;
      sub_lvl_reg <= sub_lvl_next;
      presc_reg   <= presc_next;
      div_reg     <= div_next;
      tick_reg    <= tick_next;
    end
  end

  assign lcd_tick = tick_reg;

endmodule : lcd_clock_gen

`default_nettype wire

// ### hw/lcd_segment_common_driver.sv
// LCD segment/common driver with APB registers and shared port pins
// How it works
// - Scans display memory continuously without software
// - Duty/bias field selects five modes
// - Frame field divides watch clock 512..64
// - Display off: all segments unselect
// - Mode register at ffb0, resets 00
// - LCD clock needs prescaler enable bit
// - Prescaler off stops LCD clock
// - Watch clock is main/128 or sub
// - Runs from 32.768 kHz sub clock
// - Low-voltage bit only in extended variant
// - 40 segments, 4 commons, pair ports
// - Segment pins ignore port direction
// - Segment pins read zero as port
// - Segment pins lose pull-up
// - Commons used follow duty mode
// - Word per segment, bit n per slot
// - Bit one selects, zero unselects
// - Static mode: same waveform all commons
// - Memory bits 4-7 read zero
`timescale 1ns/1ps
`default_nettype none

module lcd_segment_common_driver #(
  parameter bit LOW_VOLTAGE_VARIANT = 1'b1
) (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [lcd_pkg::ADDR_W-1:0]      paddr,
  input  wire logic [lcd_pkg::DATA_W-1:0]      pwdata,
  output logic      [lcd_pkg::DATA_W-1:0]      prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic                            sub_osc_clk,
  output logic      [2*lcd_pkg::NUM_SEG-1:0]   segment_lines,
  output logic      [2*lcd_pkg::NUM_COM-1:0]   common_lines,
  output logic      [lcd_pkg::NUM_COM-1:0]     common_open,
  output logic                                 low_voltage_mode,
  input  wire logic [lcd_pkg::NUM_PORT-1:0]    port_pin_in,
  output logic      [lcd_pkg::NUM_PORT-1:0]    port_pin_out,
  output logic      [lcd_pkg::NUM_PORT-1:0]    port_pin_oe_n,
  output logic      [lcd_pkg::NUM_PORT-1:0]    port_pullup_en
);

  localparam int NS = lcd_pkg::NUM_SEG;
  localparam int NC = lcd_pkg::NUM_COM;
  localparam int NP = lcd_pkg::NUM_PORT;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Address to register identity
  function automatic lcd_pkg::reg_id_type decode(input logic [lcd_pkg::ADDR_W-1:0] a);
    lcd_pkg::reg_id_type id;
    id = lcd_pkg::REG_NONE;
    unique case (a)
      lcd_pkg::MODE_OFS:     id = lcd_pkg::REG_MODE;
      lcd_pkg::PIN_CTRL_OFS: id = lcd_pkg::REG_PIN;
      lcd_pkg::WTM_OFS:      id = lcd_pkg::REG_WTM;
      lcd_pkg::PORT_OFS:     id = lcd_pkg::REG_PORT;
      lcd_pkg::PULLUP_OFS:   id = lcd_pkg::REG_PULL;
      lcd_pkg::STATUS_OFS:   id = lcd_pkg::REG_STAT;
      default: begin
        if (a >= lcd_pkg::DMEM_BASE && a <= lcd_pkg::DMEM_LAST && a[1:0] == 2'h0)
          id = lcd_pkg::REG_DMEM;
      end
    endcase
    return id;
  endfunction : decode

  // Last active slot index per duty
  function automatic logic [1:0] last_slot(input lcd_pkg::duty_type d);
    logic [1:0] r;
    unique case (d)
      lcd_pkg::DUTY_4_THIRD: r = 2'h3;
      lcd_pkg::DUTY_2_HALF:  r = 2'h1;
      lcd_pkg::DUTY_STATIC:  r = 2'h0;
      default:               r = 2'h2;
    endcase
    return r;
  endfunction : last_slot

  // Top ladder step: static 1, half bias 2, third bias 3
  function automatic logic [1:0] top_level(input lcd_pkg::duty_type d);
    logic [1:0] r;
    unique case (d)
      lcd_pkg::DUTY_STATIC: r = lcd_pkg::LVL_ONE;
      lcd_pkg::DUTY_2_HALF,
      lcd_pkg::DUTY_3_HALF: r = lcd_pkg::LVL_TWO;
      default:              r = lcd_pkg::LVL_TOP;
    endcase
    return r;
  endfunction : top_level

  // True for the 1/3 bias modes
  function automatic logic third_bias(input lcd_pkg::duty_type d);
    return (d == lcd_pkg::DUTY_4_THIRD) || (d == lcd_pkg::DUTY_3_THIRD);
  endfunction : third_bias

  ////////////////////////////////////////////////////////////////////////////
  // Register file state

  logic [7:0]                 mode_reg, mode_next;
  logic [7:0]                 pin_ctrl_reg, pin_ctrl_next;
  logic [1:0]                 wtm_reg, wtm_next;
  logic [NP-1:0]              port_data_reg, port_data_next;
  logic [NP-1:0]              port_dir_reg, port_dir_next;
  logic [1:0]                 pullup_reg, pullup_next;
  logic [lcd_pkg::DMEM_BITS-1:0] dmem_reg [NS];
  logic [lcd_pkg::DMEM_BITS-1:0] dmem_next [NS];
  logic [lcd_pkg::DATA_W-1:0] prdata_reg, prdata_next;
  logic                       pready_reg, pready_next;
  logic                       pslverr_reg, pslverr_next;

  lcd_pkg::reg_id_type        bus_id;
  logic [5:0]                 dmem_idx;
  logic [lcd_pkg::ADDR_W-1:0] dmem_ofs;
  logic                       bus_write;
  logic [lcd_pkg::DATA_W-1:0] rd_value;
  logic [NP-1:0]              seg_mode;
  logic [NP-1:0]              port_in_reg;
  lcd_pkg::lcd_cfg_type       cfg_reg, cfg_next, mode_cfg;
  logic [1:0]                 slot_reg, slot_next;
  logic                       pol_reg, pol_next;
  logic                       lcd_tick;

  // Segment-assigned port pins, one control bit per pair
  always_comb begin
    for (int i = 0; i < NP; i++)
      seg_mode[i] = ~pin_ctrl_reg[i/2];
  end

  // APB decode, read mux and register writes
  always_comb begin
    bus_id         = decode(paddr);
    dmem_ofs       = paddr - lcd_pkg::DMEM_BASE;
    dmem_idx       = dmem_ofs[7:2];
    bus_write      = psel & penable & pready_reg & pwrite;
    mode_next      = mode_reg;
    pin_ctrl_next  = pin_ctrl_reg;
    wtm_next       = wtm_reg;
    port_data_next = port_data_reg;
    port_dir_next  = port_dir_reg;
    pullup_next    = pullup_reg;
    dmem_next      = dmem_reg;
    rd_value       = '0;
    unique case (bus_id)
      lcd_pkg::REG_MODE: rd_value[7:0] = mode_reg;
      lcd_pkg::REG_PIN:  rd_value[7:0] = pin_ctrl_reg;
      lcd_pkg::REG_WTM:  rd_value[1:0] = wtm_reg;
      lcd_pkg::REG_PORT: begin
        rd_value[NP-1:0] = port_in_reg & ~seg_mode;
        rd_value[lcd_pkg::PORT_DIR_LSB +: NP] = port_dir_reg;
      end
      lcd_pkg::REG_PULL: rd_value[1:0] = pullup_reg;
      lcd_pkg::REG_STAT: begin
        rd_value[1:0] = slot_reg;
        rd_value[lcd_pkg::ST_POL_BIT] = pol_reg;
        rd_value[lcd_pkg::ST_DUTY_LSB +: 3] = cfg_reg.duty;
        rd_value[lcd_pkg::ST_FRAME_LSB +: 3] = cfg_reg.frame_sel;
      end
      lcd_pkg::REG_DMEM: rd_value[lcd_pkg::DMEM_BITS-1:0] = dmem_reg[dmem_idx];
      default: rd_value = '0;
    endcase
    if (bus_write) begin
      unique case (bus_id)
        lcd_pkg::REG_MODE: begin
          mode_next = pwdata[7:0];
          if (!LOW_VOLTAGE_VARIANT)
            mode_next[lcd_pkg::MODE_LV_BIT] = 1'b0;
        end
        lcd_pkg::REG_PIN:  pin_ctrl_next = pwdata[7:0];
        lcd_pkg::REG_WTM:  wtm_next = pwdata[1:0];
        lcd_pkg::REG_PORT: begin
          port_data_next = pwdata[NP-1:0];
          port_dir_next  = pwdata[lcd_pkg::PORT_DIR_LSB +: NP];
        end
        lcd_pkg::REG_PULL: pullup_next = pwdata[1:0];
        lcd_pkg::REG_DMEM: dmem_next[dmem_idx] = pwdata[lcd_pkg::DMEM_BITS-1:0];
        default: ;
      endcase
    end
    // Zero-wait answer: pready high in the access phase only
    pready_next  = psel & ~penable;
    prdata_next  = pready_next ? rd_value : prdata_reg;
    pslverr_next = pready_next ? (bus_id == lcd_pkg::REG_NONE) : 1'b0;
  end

  // Register file flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg      <= lcd_pkg::MODE_RESET;
      pin_ctrl_reg  <= lcd_pkg::PIN_CTRL_RESET;
      wtm_reg       <= lcd_pkg::WTM_RESET;
      port_data_reg <= lcd_pkg::PORT_DATA_RESET;
      port_dir_reg  <= lcd_pkg::PORT_DIR_RESET;
      pullup_reg    <= lcd_pkg::PULLUP_RESET;
      for (int i = 0; i < NS; i++)
        dmem_reg[i] <= '0;
      prdata_reg    <= '0;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
    end else begin
      mode_reg      <= mode_next;
      pin_ctrl_reg  <= pin_ctrl_next;
      wtm_reg       <= wtm_next;
      port_data_reg <= port_data_next;
      port_dir_reg  <= port_dir_next;
      pullup_reg    <= pullup_next;
      dmem_reg      <= dmem_next;
      prdata_reg    <= prdata_next;
      pready_reg    <= pready_next;
      pslverr_reg   <= pslverr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // LCD clock

  // Prescaler enable gates the LCD clock
  lcd_clock_gen u_clock (
    .pclk         (pclk),
    .presetn      (presetn),
    .sub_osc_clk  (sub_osc_clk),
    .use_sub_clk  (wtm_reg[lcd_pkg::WTM_SRC_BIT]),
    .prescaler_en (wtm_reg[lcd_pkg::WTM_PRESC_BIT]),
    .frame_sel    (cfg_reg.frame_sel),
    .lcd_tick     (lcd_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Scan sequencer

  logic [2*NS-1:0] seg_reg, seg_next;
  logic [2*NC-1:0] com_reg, com_next;
  logic [NC-1:0]   open_reg, open_next;
  logic            lv_reg;
  logic [1:0]      top;
  logic            bit_on;
  logic [1:0]      com_slot;

  // Slot stepping, polarity flip, frame-boundary config load
  always_comb begin
    // Prohibited codes fall back to 4-way
    mode_cfg.duty = (mode_reg[lcd_pkg::MODE_DUTY_LSB +: 3] > 3'(lcd_pkg::DUTY_STATIC))
                  ? lcd_pkg::DUTY_4_THIRD
                  : lcd_pkg::duty_type'(mode_reg[lcd_pkg::MODE_DUTY_LSB +: 3]);
    mode_cfg.frame_sel = mode_reg[lcd_pkg::MODE_FRAME_LSB +: 3];
    cfg_next  = cfg_reg;
    slot_next = slot_reg;
    pol_next  = pol_reg;
    if (!mode_reg[lcd_pkg::MODE_ON_BIT] && mode_cfg != cfg_reg) begin
      cfg_next  = mode_cfg;
      slot_next = 2'h0;
    end else if (lcd_tick) begin
      // One slot per LCD clock, flip per frame
      if (slot_reg >= last_slot(cfg_reg.duty)) begin
        slot_next = 2'h0;
        pol_next  = ~pol_reg;
        // With display on, new mode only at frame boundary; display off loads it at once
        cfg_next  = mode_cfg;
      end else begin
        slot_next = slot_reg + 2'h1;
      end
    end
  end

  // Common and segment drive levels
  always_comb begin
    top       = top_level(cfg_reg.duty);
    open_next = '0;
    com_next  = '0;
    seg_next  = '0;
    bit_on    = 1'b0;
    com_slot  = 2'h0;
    for (int c = 0; c < NC; c++) begin
      com_slot = 2'(c);
      // Static: every common gets slot 0 wave
      if (cfg_reg.duty == lcd_pkg::DUTY_STATIC)
        com_slot = 2'h0;
      open_next[c] = (com_slot > last_slot(cfg_reg.duty));
      if (com_slot == slot_reg)
        com_next[2*c +: 2] = pol_reg ? top : lcd_pkg::LVL_ZERO;
      else if (third_bias(cfg_reg.duty))
        com_next[2*c +: 2] = pol_reg ? lcd_pkg::LVL_ONE : lcd_pkg::LVL_TWO;
      else
        com_next[2*c +: 2] = lcd_pkg::LVL_ONE;
    end
    for (int s = 0; s < NS; s++) begin
      bit_on = dmem_reg[s][slot_reg];
      if (!mode_reg[lcd_pkg::MODE_ON_BIT])
        bit_on = 1'b0;
      if (bit_on)
        seg_next[2*s +: 2] = pol_reg ? lcd_pkg::LVL_ZERO : top;
      else if (third_bias(cfg_reg.duty))
        seg_next[2*s +: 2] = pol_reg ? lcd_pkg::LVL_TWO : lcd_pkg::LVL_ONE;
      else
        seg_next[2*s +: 2] = pol_reg ? top : lcd_pkg::LVL_ZERO;
      if (s >= lcd_pkg::PORT_SEG_BASE && !seg_mode[s - lcd_pkg::PORT_SEG_BASE])
        seg_next[2*s +: 2] = lcd_pkg::LVL_ZERO;
    end
  end

  // Scan flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg  <= lcd_pkg::lcd_cfg_type'('0);
      slot_reg <= 2'h0;
      pol_reg  <= 1'b0;
      seg_reg  <= '0;
      com_reg  <= '0;
      open_reg <= '0;
      lv_reg   <= 1'b0;
    end else begin
      cfg_reg  <= cfg_next;
      slot_reg <= slot_next;
      pol_reg  <= pol_next;
      seg_reg  <= seg_next;
      com_reg  <= com_next;
      open_reg <= open_next;
      lv_reg   <= mode_reg[lcd_pkg::MODE_LV_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared port pins

  logic [NP-1:0] sync1_reg, sync2_reg, sync3_reg, port_in_next;
  logic [NP-1:0] pout_reg, oe_n_reg, oe_n_next, pull_reg, pull_next;

  // Filtered pin level, port drive and pull-up gating
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      port_in_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : port_in_reg[i];
      // Segment pins never driven as port
      oe_n_next[i] = seg_mode[i] | port_dir_reg[i];
      pull_next[i] = ~seg_mode[i] & port_dir_reg[i]
                   & pullup_reg[(i < lcd_pkg::PORT_HALF) ? 1 : 0];
    end
  end

  // Port flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg   <= '0;
      sync2_reg   <= '0;
      sync3_reg   <= '0;
      port_in_reg <= '0;
      pout_reg    <= '0;
      oe_n_reg    <= '1;
      pull_reg    <= '0;
    end else begin
      sync1_reg   <= port_pin_in;
      sync2_reg   <= sync1_reg;
      sync3_reg   <= sync2_reg;
      port_in_reg <= port_in_next;
      pout_reg    <= port_data_reg;
      oe_n_reg    <= oe_n_next;
      pull_reg    <= pull_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign segment_lines    = seg_reg;
  assign common_lines     = com_reg;
  assign common_open      = open_reg;
  assign low_voltage_mode = lv_reg;
  assign port_pin_out     = pout_reg;
  assign port_pin_oe_n    = oe_n_reg;
  assign port_pullup_en   = pull_reg;

endmodule : lcd_segment_common_driver

`default_nettype wire

// ### verification/lcd_drv_chk.sv
// Port checker for the LCD segment/common driver
`timescale 1ns/1ps
`default_nettype none
module lcd_drv_chk #(
  parameter bit LOW_VOLTAGE_VARIANT = 1'b1
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  common_open,
  input wire logic        low_voltage_mode,
  input wire logic [15:0] port_pin_oe_n,
  input wire logic [15:0] port_pullup_en
);
  logic mapped;
  logic in_dmem;
  logic mode_wr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Address decode seen by the bus
  assign in_dmem = paddr >= lcd_pkg::DMEM_BASE && paddr <= lcd_pkg::DMEM_LAST && paddr[1:0] == 2'h0;
  assign mapped = in_dmem || paddr inside {lcd_pkg::MODE_OFS, lcd_pkg::PIN_CTRL_OFS, lcd_pkg::WTM_OFS,
                                           lcd_pkg::PORT_OFS, lcd_pkg::PULLUP_OFS, lcd_pkg::STATUS_OFS};
  assign mode_wr = pready && pwrite && paddr == lcd_pkg::MODE_OFS;
  ////////////////////////////////////////////////////////////////////////
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_err_decode: assert property (pready |-> pslverr == !mapped)
    else $error("error flag wrong for address");
  chk_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  chk_dmem_high_zero: assert property (pready && !pwrite && in_dmem |-> prdata[31:4] == 28'h0)
    else $error("memory high bits not zero");
  chk_lv_follow: assert property (mode_wr |=> ##1 low_voltage_mode == ($past(pwdata[3], 2) && LOW_VOLTAGE_VARIANT))
    else $error("low-voltage output wrong");
  chk_common_usage: assert property (!common_open[0] && !common_open[1] && (!common_open[2] || common_open[3]))
    else $error("common open pattern illegal");
  chk_pull_not_driven: assert property ((port_pin_oe_n | ~port_pullup_en) == 16'hffff)
    else $error("pull-up on driven pin");
  // Main scenarios
  cov_display_on: cover property (mode_wr && pwdata[7]);
  cov_refused: cover property (pready && pslverr);
  cov_two_way: cover property (common_open == 4'hc);
endmodule : lcd_drv_chk
bind lcd_segment_common_driver lcd_drv_chk #(.LOW_VOLTAGE_VARIANT(LOW_VOLTAGE_VARIANT)) chk_inst (.*);
`default_nettype wire

// ### verification/lcd_panel_model.sv
// Passive glass model: pixels lit on the first common
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
  input wire logic [2*lcd_pkg::NUM_SEG-1:0] segment_lines,
  input wire logic [2*lcd_pkg::NUM_COM-1:0] common_lines,
  input wire logic [lcd_pkg::NUM_COM-1:0]   common_open,
  output logic     [lcd_pkg::NUM_SEG-1:0]   lit_com0
);
  // Pixel lights on a two-step or larger difference
  always_comb begin
    int d;
    d = 0;
    for (int s = 0; s < lcd_pkg::NUM_SEG; s++) begin
      d = int'(segment_lines[2*s +: 2]) - int'(common_lines[1:0]);
      lit_com0[s] = !common_open[0] && (d >= 2 || d <= -2);
    end
  end
endmodule : lcd_panel_model
`default_nettype wire

// ### verification/tb_top.sv
// Register-level testbench of the LCD segment/common driver
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk = 1'b0;
  logic        sub_clk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [79:0] segment_lines;
  logic [7:0]  common_lines;
  logic [3:0]  common_open;
  logic        low_voltage_mode;
  logic [15:0] port_pin_in;
  logic [15:0] port_pin_out;
  logic [15:0] port_pin_oe_n;
  logic [15:0] port_pullup_en;
  logic [39:0] lit_com0;
  logic [32:0] rdat;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  always #4 pclk = ~pclk;
  // Fast stand-in sub oscillator, toggled between rising edges of pclk
  always #32 sub_clk = ~sub_clk;
  // Pin level: own drive where enabled, else external high
  assign port_pin_in = (~port_pin_oe_n & port_pin_out) | port_pin_oe_n;
  lcd_segment_common_driver lcd_segment_common_driver_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sub_osc_clk(sub_clk), .segment_lines(segment_lines), .common_lines(common_lines),
    .common_open(common_open), .low_voltage_mode(low_voltage_mode), .port_pin_in(port_pin_in),
    .port_pin_out(port_pin_out), .port_pin_oe_n(port_pin_oe_n), .port_pullup_en(port_pullup_en));
  lcd_panel_model lcd_panel_model_inst (.segment_lines(segment_lines), .common_lines(common_lines),
    .common_open(common_open), .lit_com0(lit_com0));
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    if (n == 16) fail_count++;
    rdat = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [15:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0);
    chk(80'(rdat), 80'(e));
  endtask : rd
  task automatic wait_com(input int lim);
    logic [7:0] c;
    int n;
    c = common_lines;
    n = 0;
    while (common_lines === c && n < lim) begin
      n++;
      @(posedge pclk);
    end
    if (n == lim) fail_count++;
    repeat (2) @(posedge pclk);
  endtask : wait_com
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [2:0] f;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(80'(segment_lines), {40{2'b01}});
    rd(lcd_pkg::MODE_OFS, 33'h0);
    rd(lcd_pkg::WTM_OFS, 33'h0);
    rd(lcd_pkg::PORT_OFS, 33'h0ffff0000);
    rd(16'hffc8, 33'h100000000);
    apb(1'b1, lcd_pkg::DMEM_BASE, 32'hf1);
    rd(lcd_pkg::DMEM_BASE, 33'h1);
    apb(1'b1, lcd_pkg::DMEM_BASE + 16'h4, 32'h2);
    apb(1'b1, lcd_pkg::DMEM_LAST, 32'ha5);
    rd(lcd_pkg::DMEM_LAST, 33'h5);
    for (int d = 0; d < 5; d++) begin
      f = 3'(d % 4);
      apb(1'b1, lcd_pkg::MODE_OFS, {24'h0, 1'b0, f, 1'b0, 3'(d)});
      rd(lcd_pkg::STATUS_OFS, {24'h0, f, 3'(d), 3'h0});
      chk(80'(common_open), 80'(20'h08c80 >> (4 * d)) & 80'hf);
    end
    apb(1'b1, lcd_pkg::MODE_OFS, 32'h5);
    rd(lcd_pkg::STATUS_OFS, 33'h0);
    apb(1'b1, lcd_pkg::MODE_OFS, 32'h8);
    repeat (3) @(posedge pclk);
    chk(80'(low_voltage_mode), 80'h1);
    apb(1'b1, lcd_pkg::MODE_OFS, 32'h0);
    apb(1'b1, lcd_pkg::PIN_CTRL_OFS, 32'h1);
    apb(1'b1, lcd_pkg::PULLUP_OFS, 32'h2);
    repeat (4) @(posedge pclk);
    rd(lcd_pkg::PORT_OFS, 33'h0ffff0003);
    chk(80'(port_pullup_en), 80'h0003);
    apb(1'b1, lcd_pkg::PORT_OFS, 32'h0000ffff);
    repeat (2) @(posedge pclk);
    chk(80'({port_pin_out, port_pin_oe_n}), 80'hfffffffc);
    apb(1'b1, lcd_pkg::WTM_OFS, 32'h2);
    apb(1'b1, lcd_pkg::MODE_OFS, 32'h32);
    apb(1'b1, lcd_pkg::MODE_OFS, 32'hb2);
    repeat (3) @(posedge pclk);
    chk(80'({common_lines[3:0], segment_lines[3:0], lit_com0[1:0]}), 80'({4'h4, 4'h2, 2'h1}));
    wait_com(20000);
    chk(80'(segment_lines[3:0]), 80'h8);
    rd(lcd_pkg::STATUS_OFS, 33'hd1);
    wait_com(20000);
    chk(80'({common_lines[1:0], segment_lines[3:0]}), 80'h28);
    apb(1'b1, lcd_pkg::MODE_OFS, 32'hb3);
    rd(lcd_pkg::STATUS_OFS, 33'hd4);
    apb(1'b1, lcd_pkg::WTM_OFS, 32'h0);
    repeat (9000) @(posedge pclk);
    rd(lcd_pkg::STATUS_OFS, 33'hd4);
    // Sub oscillator source: slots must step far sooner than from pclk/128
    apb(1'b1, lcd_pkg::WTM_OFS, 32'h3);
    wait_com(1200);
    wait_com(1200);
    rd(lcd_pkg::STATUS_OFS, 33'hd8);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
